// File: hdl/fmdc_pkg.sv
package fmdc_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS = 1000000 / TICK_NS;

  // Protection and start timing, nominal figures
  localparam int LOCK_ON_MS = 500;
  localparam int LOCK_OFF_MS = 5000;
  localparam int STANDBY_MS = 1;
  localparam int ASSIST_MAX_MS = 250;
  localparam int ASSIST_HZ = 33000;
  localparam int LOCK_ON_TICKS = LOCK_ON_MS * TICKS_PER_MS;
  localparam int LOCK_OFF_TICKS = LOCK_OFF_MS * TICKS_PER_MS;
  localparam int STANDBY_TICKS = STANDBY_MS * TICKS_PER_MS;
  localparam int ASSIST_TICKS = ASSIST_MAX_MS * TICKS_PER_MS;
  localparam int CHOP_HALF_CYC = CLK_HZ / (2 * ASSIST_HZ);
  localparam int CNT_W = 23;
  localparam int CHOP_W = 12;
  localparam int TICK_W = 8;

  // Register map
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
  localparam int CTRL_LOCK_EN = 0;
  localparam int CTRL_ASSIST_OK = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int EVT_W = 4;
  localparam logic [3:0] INT_MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_ASSIST = 2'b01,
    ST_RUN = 2'b10,
    ST_LOCKOFF = 2'b11
  } fmdc_state_t;

  typedef struct packed {
    logic rotate;
    logic restart;
    logic standby;
    logic lock_trip;
  } fmdc_evt_t;

  typedef struct packed {
    logic coil_a;
    logic coil_b;
    logic bias;
    logic tacho_oe_n;
  } fmdc_drive_t;
endpackage

// File: hdl/fmdc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fmdc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// File: hdl/fmdc_tick.sv
`timescale 1ns/1ps
`default_nettype none
module fmdc_tick #(
  parameter int DIV = fmdc_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // One-cycle pulse every DIV cycles
  output logic tick
);
  logic [fmdc_pkg::TICK_W-1:0] cnt_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt_ff == fmdc_pkg::TICK_W'(DIV - 1));
      cnt_ff <= (cnt_ff == fmdc_pkg::TICK_W'(DIV - 1)) ? '0 : cnt_ff + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: hdl/fmdc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] Lock on-time 0.50 s from internal counter
// [R2] Lock off-time 5.0 s, same counter
// [R3] No sensor edge: outputs off, retry
// [R4] Speed input low turns high side off
// [R5] Open speed input means full drive
// [R6] Host drives speed input above 2kHz
// [R7] Speed low over 1ms disables protection
// [R8] Speed resumes: drive at once
// [R9] Standby: bias off, tacho released
// [R10] Polarity selects outputs and tacho level
// [R11] Start assist: 50% at 33kHz, 250ms max
// [R12] Assist ignores duty, except zero duty
// [R13] Select pin low enables start assist
// [R14] Tacho needs external pull-up
module fmdc_top #(
  parameter int LOCK_ON_TICKS = fmdc_pkg::LOCK_ON_TICKS,
  parameter int LOCK_OFF_TICKS = fmdc_pkg::LOCK_OFF_TICKS,
  parameter int STANDBY_TICKS = fmdc_pkg::STANDBY_TICKS,
  parameter int ASSIST_TICKS = fmdc_pkg::ASSIST_TICKS,
  parameter int TICK_DIV = fmdc_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fmdc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Sensor and host pins
  input wire logic hall_pos_in,
  input wire logic hall_neg_in,
  input wire logic speed_in,
  input wire logic sel_in,
  // Motor and tacho pins
  output logic coil_drive_a,
  output logic coil_drive_b,
  output logic sensor_bias_out,
  output logic tacho_pulse_out_o,
  output logic tacho_pulse_out_oe_n
);
  localparam int CW = fmdc_pkg::CNT_W;

  function automatic logic hit(input logic [CW-1:0] c, input int lim);
    hit = (c == CW'(lim - 1));
  endfunction

  fmdc_pkg::fmdc_state_t state_ff, nxt_state;
  fmdc_pkg::fmdc_drive_t nxt_drv;
  fmdc_pkg::fmdc_evt_t evt;
  logic [3:0] pins_s;
  logic hall_pos_s, hall_neg_s, speed_s, sel_s, pol, pol_ff, hall_edge, tick;
  logic [CW-1:0] on_cnt_ff, off_cnt_ff, assist_cnt_ff, low_cnt_ff;
  logic [fmdc_pkg::CHOP_W-1:0] chop_cnt_ff;
  logic chop_ff, lock_done, off_done, assist_done, low_done, assist_en;
  logic [1:0] ctrl_ff;
  logic [fmdc_pkg::EVT_W-1:0] int_stat_ff, int_mask_ff, w1c;
  logic wr_en, acc_setup;
  logic [31:0] rd_mux;
  logic rd_err;
  fmdc_pkg::fmdc_state_t start_state;

  // Open speed pin reads high through the pad pull-up; reset agrees
  fmdc_sync #(.W(4), .RST_VAL(4'h6)) u_sync ( // R5
    .pclk(pclk),
    .presetn(presetn),
    .d({hall_pos_in, speed_in, sel_in, hall_neg_in}),
    .q(pins_s)
  );
  assign {hall_pos_s, speed_s, sel_s, hall_neg_s} = pins_s;

  fmdc_tick #(.DIV(TICK_DIV)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  assign pol = hall_pos_s & ~hall_neg_s;
  assign hall_edge = pol ^ pol_ff;
  assign assist_en = ~sel_s & ctrl_ff[fmdc_pkg::CTRL_ASSIST_OK]; // R13
  assign start_state = assist_en ? fmdc_pkg::ST_ASSIST : fmdc_pkg::ST_RUN;
  assign lock_done = ctrl_ff[fmdc_pkg::CTRL_LOCK_EN] & tick & ~hall_edge
                     & hit(on_cnt_ff, LOCK_ON_TICKS); // R1
  assign off_done = tick & hit(off_cnt_ff, LOCK_OFF_TICKS); // R2
  assign assist_done = tick & hit(assist_cnt_ff, ASSIST_TICKS); // R11
  // Strictly more than the limit: the count already holds it
  assign low_done = tick & ~speed_s & (low_cnt_ff == CW'(STANDBY_TICKS)); // R7

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pol_ff <= 1'b0;
    else
      pol_ff <= pol;
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      fmdc_pkg::ST_STANDBY:
        if (speed_s)
          nxt_state = start_state; // R8
      fmdc_pkg::ST_ASSIST:
        if (low_done)
          nxt_state = fmdc_pkg::ST_STANDBY; // R12
        else if (hall_edge || assist_done)
          nxt_state = fmdc_pkg::ST_RUN; // R11
        else if (lock_done)
          nxt_state = fmdc_pkg::ST_LOCKOFF;
      fmdc_pkg::ST_RUN:
        if (low_done)
          nxt_state = fmdc_pkg::ST_STANDBY; // R7
        else if (lock_done)
          nxt_state = fmdc_pkg::ST_LOCKOFF; // R3
      fmdc_pkg::ST_LOCKOFF:
        if (low_done)
          nxt_state = fmdc_pkg::ST_STANDBY;
        else if (off_done)
          nxt_state = start_state; // R3
      default:
        nxt_state = fmdc_pkg::ST_STANDBY;
    endcase
  end

  // Power-up passes through standby so a held-low speed pin never spins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= fmdc_pkg::ST_STANDBY;
    else
      state_ff <= nxt_state;
  end

  // On-time runs across assist and run; any sensor edge restarts it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      on_cnt_ff <= '0;
    else if (hall_edge || state_ff == fmdc_pkg::ST_STANDBY
             || state_ff == fmdc_pkg::ST_LOCKOFF
             || nxt_state == fmdc_pkg::ST_STANDBY
             || nxt_state == fmdc_pkg::ST_LOCKOFF)
      on_cnt_ff <= '0; // R3
    else if (tick)
      on_cnt_ff <= on_cnt_ff + 1'b1; // R1
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      off_cnt_ff <= '0;
    else if (state_ff != fmdc_pkg::ST_LOCKOFF)
      off_cnt_ff <= '0;
    else if (tick)
      off_cnt_ff <= off_cnt_ff + 1'b1; // R2
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      assist_cnt_ff <= '0;
    else if (state_ff != fmdc_pkg::ST_ASSIST)
      assist_cnt_ff <= '0;
    else if (tick)
      assist_cnt_ff <= assist_cnt_ff + 1'b1; // R11
  end

  // Saturates so a long stop cannot wrap back below the limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cnt_ff <= '0;
    else if (speed_s)
      low_cnt_ff <= '0;
    else if (tick && low_cnt_ff != CW'(STANDBY_TICKS))
      low_cnt_ff <= low_cnt_ff + 1'b1; // R7
  end

  // Free-running chopper; assist phase is not aligned to its entry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chop_cnt_ff <= '0;
      chop_ff <= 1'b0;
    end
    else if (chop_cnt_ff == fmdc_pkg::CHOP_W'(fmdc_pkg::CHOP_HALF_CYC - 1))
    begin
      chop_cnt_ff <= '0;
      chop_ff <= ~chop_ff; // R11
    end
    else
      chop_cnt_ff <= chop_cnt_ff + 1'b1;
  end

  always_comb
  begin
    nxt_drv = '{coil_a: 1'b0, coil_b: 1'b0, bias: 1'b1, tacho_oe_n: pol}; // R10
    case (state_ff)
      fmdc_pkg::ST_RUN:
      begin
        nxt_drv.coil_a = pol & speed_s; // R4
        nxt_drv.coil_b = ~pol & speed_s; // R10
      end
      fmdc_pkg::ST_ASSIST:
      begin
        nxt_drv.coil_a = pol & chop_ff; // R12
        nxt_drv.coil_b = ~pol & chop_ff; // R11
      end
      fmdc_pkg::ST_STANDBY:
      begin
        nxt_drv.bias = 1'b0; // R9
        nxt_drv.tacho_oe_n = 1'b1; // R9
      end
      default:
        nxt_drv.bias = 1'b1;
    endcase
  end

  // Tacho only pulls low or lets go; the board supplies the high level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      coil_drive_a <= 1'b0;
      coil_drive_b <= 1'b0;
      sensor_bias_out <= 1'b0;
      tacho_pulse_out_oe_n <= 1'b1;
      tacho_pulse_out_o <= 1'b0;
    end
    else
    begin
      coil_drive_a <= nxt_drv.coil_a;
      coil_drive_b <= nxt_drv.coil_b;
      sensor_bias_out <= nxt_drv.bias;
      tacho_pulse_out_oe_n <= nxt_drv.tacho_oe_n; // R14
      tacho_pulse_out_o <= 1'b0;
    end
  end

  // Events and interrupt
  assign evt.lock_trip = (nxt_state == fmdc_pkg::ST_LOCKOFF)
                         && (state_ff != fmdc_pkg::ST_LOCKOFF);
  assign evt.standby = (nxt_state == fmdc_pkg::ST_STANDBY)
                       && (state_ff != fmdc_pkg::ST_STANDBY);
  assign evt.restart = ((state_ff == fmdc_pkg::ST_STANDBY)
                        || (state_ff == fmdc_pkg::ST_LOCKOFF))
                       && ((nxt_state == fmdc_pkg::ST_RUN)
                           || (nxt_state == fmdc_pkg::ST_ASSIST));
  assign evt.rotate = (state_ff == fmdc_pkg::ST_ASSIST) && hall_edge;

  // APB: one wait-free access phase, registered answer
  assign acc_setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;
  assign w1c = (wr_en && paddr == fmdc_pkg::ADDR_INT_STAT)
               ? pwdata[fmdc_pkg::EVT_W-1:0] : '0;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      fmdc_pkg::ADDR_CTRL: rd_mux[1:0] = ctrl_ff;
      fmdc_pkg::ADDR_STATUS: rd_mux[4:0] = {assist_en, speed_s, pol, state_ff};
      fmdc_pkg::ADDR_INT_STAT: rd_mux[fmdc_pkg::EVT_W-1:0] = int_stat_ff;
      fmdc_pkg::ADDR_INT_MASK: rd_mux[fmdc_pkg::EVT_W-1:0] = int_mask_ff;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= acc_setup;
      pslverr <= acc_setup & rd_err;
      prdata <= (acc_setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= fmdc_pkg::CTRL_RST;
      int_mask_ff <= fmdc_pkg::INT_MASK_RST;
    end
    else if (wr_en && paddr == fmdc_pkg::ADDR_CTRL)
      ctrl_ff <= pwdata[1:0];
    else if (wr_en && paddr == fmdc_pkg::ADDR_INT_MASK)
      int_mask_ff <= pwdata[fmdc_pkg::EVT_W-1:0];
  end

  // New event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_stat_ff <= '0;
      irq <= 1'b0;
    end
    else
    begin
      int_stat_ff <= (int_stat_ff & ~w1c) | evt;
      irq <= |(((int_stat_ff & ~w1c) | evt) & int_mask_ff);
    end
  end

  // Checks
  property p_speed_low_off;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == fmdc_pkg::ST_RUN && !speed_s) |=> (!coil_drive_a && !coil_drive_b);
  endproperty
  a_speed_low_off: assert property (p_speed_low_off) else $error("drive with speed low"); // R4

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == fmdc_pkg::ST_RUN && speed_s)
      |=> (coil_drive_a == $past(pol)) && (coil_drive_b == !$past(pol))
          && (tacho_pulse_out_oe_n == $past(pol));
  endproperty
  a_polarity: assert property (p_polarity) else $error("outputs disagree with sensor"); // R10

  property p_standby_pins;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == fmdc_pkg::ST_STANDBY) |=> (!sensor_bias_out && tacho_pulse_out_oe_n);
  endproperty
  a_standby_pins: assert property (p_standby_pins) else $error("standby pins wrong"); // R9

  property p_lockoff_quiet;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == fmdc_pkg::ST_LOCKOFF) |=> (!coil_drive_a && !coil_drive_b);
  endproperty
  a_lockoff_quiet: assert property (p_lockoff_quiet) else $error("drive during off-time"); // R3

  property p_lock_on_time;
    @(posedge pclk) disable iff (!presetn)
    (state_ff != fmdc_pkg::ST_LOCKOFF) ##1 (state_ff == fmdc_pkg::ST_LOCKOFF)
      |-> ($past(on_cnt_ff) == CW'(LOCK_ON_TICKS - 1)) && $past(tick);
  endproperty
  a_lock_on_time: assert property (p_lock_on_time) else $error("lock trip at wrong time"); // R1

  property p_lock_off_time;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == fmdc_pkg::ST_LOCKOFF) ##1 (state_ff != fmdc_pkg::ST_LOCKOFF)
      && (state_ff != fmdc_pkg::ST_STANDBY)
      |-> $past(off_cnt_ff) == CW'(LOCK_OFF_TICKS - 1);
  endproperty
  a_lock_off_time: assert property (p_lock_off_time) else $error("retry at wrong time"); // R2

  property p_standby_entry;
    @(posedge pclk) disable iff (!presetn)
    (state_ff != fmdc_pkg::ST_STANDBY) ##1 (state_ff == fmdc_pkg::ST_STANDBY)
      |-> ($past(low_cnt_ff) == CW'(STANDBY_TICKS)) && !$past(speed_s);
  endproperty
  a_standby_entry: assert property (p_standby_entry) else $error("standby entry early"); // R7

  property p_quick_start;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == fmdc_pkg::ST_STANDBY && speed_s) |=> (state_ff == $past(start_state)) ##1
      (sensor_bias_out);
  endproperty
  a_quick_start: assert property (p_quick_start) else $error("no immediate restart"); // R8

  property p_assist_chop;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == fmdc_pkg::ST_ASSIST)
      |=> (coil_drive_a == ($past(pol) && $past(chop_ff)))
          && (coil_drive_b == (!$past(pol) && $past(chop_ff)));
  endproperty
  a_assist_chop: assert property (p_assist_chop) else $error("assist drive not chopped"); // R12

  property p_assist_max;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == fmdc_pkg::ST_ASSIST) |-> assist_cnt_ff < CW'(ASSIST_TICKS);
  endproperty
  a_assist_max: assert property (p_assist_max) else $error("assist too long"); // R11

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    ##1 (irq == |$past((int_stat_ff & ~w1c | evt) & int_mask_ff));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  c_lock_trip: cover property (@(posedge pclk) disable iff (!presetn) evt.lock_trip);
  c_standby: cover property (@(posedge pclk) disable iff (!presetn) evt.standby);
  c_retry: cover property (@(posedge pclk) disable iff (!presetn)
    state_ff == fmdc_pkg::ST_LOCKOFF ##1 state_ff == fmdc_pkg::ST_ASSIST);
  c_rotate: cover property (@(posedge pclk) disable iff (!presetn) evt.rotate);
endmodule
`default_nettype wire

// File: tb/fan_motor_drive_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fan_motor_drive_control_tb;
  localparam int ON_T = 50;
  localparam int OFF_T = 200;
  localparam int SBY_T = 10;
  localparam int AST_T = 4000;
  localparam int DIV = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic hall_pos_in, hall_neg_in, coil_drive_a, coil_drive_b, sensor_bias_out;
  logic tacho_o, tacho_oe_n, tacho_line, stall, spd_en, spd_drv, sel_en, drv;
  tri1 speed_pin;
  tri1 sel_pin;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  // Open pins float to the pull-up level
  assign speed_pin = spd_en ? spd_drv : 1'bz;
  assign sel_pin = sel_en ? 1'b0 : 1'bz;
  assign drv = hall_pos_in ? coil_drive_a : coil_drive_b;

  fmdc_top #(.LOCK_ON_TICKS(ON_T), .LOCK_OFF_TICKS(OFF_T), .STANDBY_TICKS(SBY_T),
    .ASSIST_TICKS(AST_T), .TICK_DIV(DIV)) fmdc_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .hall_pos_in(hall_pos_in), .hall_neg_in(hall_neg_in), .speed_in(speed_pin),
    .sel_in(sel_pin), .coil_drive_a(coil_drive_a), .coil_drive_b(coil_drive_b),
    .sensor_bias_out(sensor_bias_out), .tacho_pulse_out_o(tacho_o),
    .tacho_pulse_out_oe_n(tacho_oe_n));
  fmdc_motor_model fmdc_motor_model_i (.pclk(pclk), .coil_a(coil_drive_a),
    .coil_b(coil_drive_b), .tacho_o(tacho_o), .tacho_oe_n(tacho_oe_n), .stall(stall),
    .hall_pos(hall_pos_in), .hall_neg(hall_neg_in), .tacho_line(tacho_line));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task close_out;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run needs about 19000 cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      close_out;
    end
  end

  task chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      $display("BAD %s exp %b got %b", nm, e, g);
      n_errors++;
    end
  endtask

  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask

  task chk_range(input string nm, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi)
    begin
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
      n_errors++;
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    chk_bit("pready", 1'b1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_word(nm, e, rd & m);
  endtask

  task wait_coils(input logic act, output int n);
    n = 0;
    while ((coil_drive_a | coil_drive_b) !== act && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Pin levels only judged once sensor and speed have settled
  task chk_pins(input logic on, input int n);
    int st;
    logic p;
    repeat (6) @(posedge pclk);
    st = 0;
    p = hall_pos_in;
    repeat (n)
    begin
      @(posedge pclk);
      st = (hall_pos_in === p) ? st + 1 : 0;
      p = hall_pos_in;
      if (st > 5)
      begin
        chk_bit("coil_a", on & p, coil_drive_a);
        chk_bit("coil_b", on & ~p, coil_drive_b);
        chk_bit("tacho", p, tacho_line);
      end
    end
  endtask

  task t_regs;
    rd_chk("ctrl", fmdc_pkg::ADDR_CTRL, 32'h3, 32'h3);
    rd_chk("int_mask", fmdc_pkg::ADDR_INT_MASK, 32'hf, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk_bit("slverr", 1'b1, err);
    chk_word("unmapped", 32'h0, rd);
    apb(1'b1, fmdc_pkg::ADDR_INT_MASK, 32'h5);
    rd_chk("int_mask", fmdc_pkg::ADDR_INT_MASK, 32'hf, 32'h5);
  endtask

  task t_run;
    spd_drv <= 1'b0;
    chk_pins(1'b0, 25);
    spd_en <= 1'b0;
    chk_pins(1'b1, 300);
  endtask

  task t_lock;
    int n;
    apb(1'b1, fmdc_pkg::ADDR_INT_STAT, 32'hf);
    apb(1'b1, fmdc_pkg::ADDR_INT_MASK, 32'h1);
    stall <= 1'b1;
    wait_coils(1'b0, n);
    repeat (3) @(posedge pclk);
    chk_bit("irq", 1'b1, irq);
    rd_chk("int_stat", fmdc_pkg::ADDR_INT_STAT, 32'h1, 32'h1);
    apb(1'b1, fmdc_pkg::ADDR_INT_STAT, 32'h1);
    repeat (3) @(posedge pclk);
    chk_bit("irq", 1'b0, irq);
    wait_coils(1'b1, n);
    wait_coils(1'b0, n);
    chk_range("lock_on", ON_T * DIV - 8, ON_T * DIV + 8, n);
    wait_coils(1'b1, n);
    chk_range("lock_off", OFF_T * DIV - 8, OFF_T * DIV + 8, n);
    wait_coils(1'b0, n);
  endtask

  task t_standby;
    int n;
    spd_en <= 1'b1;
    spd_drv <= 1'b0;
    apb(1'b1, fmdc_pkg::ADDR_INT_STAT, 32'hf);
    repeat (SBY_T * DIV + 20) @(posedge pclk);
    chk_bit("bias", 1'b0, sensor_bias_out);
    chk_bit("tacho", 1'b1, tacho_line);
    rd_chk("state", fmdc_pkg::ADDR_STATUS, 32'h3, 32'h0);
    rd_chk("int_stat", fmdc_pkg::ADDR_INT_STAT, 32'h2, 32'h2);
    apb(1'b1, fmdc_pkg::ADDR_INT_STAT, 32'hf);
    repeat (ON_T * DIV * 2) @(posedge pclk);
    rd_chk("int_stat", fmdc_pkg::ADDR_INT_STAT, 32'h1, 32'h0);
    spd_drv <= 1'b1;
    wait_coils(1'b1, n);
    chk_range("quick_start", 1, 8, n);
  endtask

  // Active coil stays put for one chop half; optional speed dip inside it
  task chop_half(input logic dip, output int n);
    logic p;
    p = drv;
    n = 0;
    while (drv === p && n < 7000)
    begin
      @(posedge pclk);
      n++;
      if (dip)
        spd_drv <= (n >= 20);
    end
  endtask

  task t_assist;
    int n;
    int t0;
    spd_drv <= 1'b0;
    sel_en <= 1'b1;
    apb(1'b1, fmdc_pkg::ADDR_CTRL, 32'h2);
    repeat (SBY_T * DIV + 20) @(posedge pclk);
    repeat (50)
    begin
      @(posedge pclk);
      chk_bit("zero_duty", 1'b0, coil_drive_a | coil_drive_b);
    end
    spd_drv <= 1'b1;
    t0 = cyc;
    repeat (10) @(posedge pclk);
    rd_chk("state", fmdc_pkg::ADDR_STATUS, 32'h3, 32'h1);
    chop_half(1'b0, n);
    chop_half(1'b1, n);
    chk_range("chop_high", 3029, 3031, n);
    chop_half(1'b0, n);
    chk_range("chop_low", 3029, 3031, n);
    rd = 32'h0;
    while (rd[1:0] !== 2'h2 && cyc - t0 < 20000)
      apb(1'b0, fmdc_pkg::ADDR_STATUS, 32'h0);
    chk_range("assist_max", AST_T * DIV - 20, AST_T * DIV + 20, cyc - t0);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stall = 1'b0;
    spd_en = 1'b1;
    spd_drv = 1'b1;
    sel_en = 1'b0;
    repeat (6) @(posedge pclk);
    chk_bit("rst_coil", 1'b0, coil_drive_a | coil_drive_b);
    chk_bit("rst_bias", 1'b0, sensor_bias_out);
    chk_bit("rst_tacho", 1'b1, tacho_line);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs;
    t_run;
    t_lock;
    t_standby;
    t_assist;
    close_out;
  end
endmodule
`default_nettype wire

// File: tb/fmdc_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module fmdc_motor_model (
  // Clock
  input wire logic pclk,
  // Coil and tacho from the driver
  input wire logic coil_a,
  input wire logic coil_b,
  input wire logic tacho_o,
  input wire logic tacho_oe_n,
  // Bench control
  input wire logic stall,
  // Sensor and tacho line
  output logic hall_pos,
  output logic hall_neg,
  output logic tacho_line
);
  logic pol_ff = 1'b1;
  logic [5:0] ang_ff = 6'h00;
  // Rotor turns only while a coil is driven and it is not held
  always_ff @(posedge pclk)
  begin
    if (!stall && (coil_a || coil_b))
    begin
      ang_ff <= ang_ff + 6'h01;
      if (ang_ff == 6'h3f)
        pol_ff <= ~pol_ff;
    end
  end
  assign hall_pos = pol_ff;
  assign hall_neg = ~pol_ff;
  // Board pull-up on the open-drain line
  assign tacho_line = tacho_oe_n ? 1'b1 : tacho_o;
endmodule
`default_nettype wire
